// ### rtl/tcc_pkg.sv
// Constants, encodings and carrier types for the timer capture/compare block.
// Assumes one timer clock domain; every user needs nothing else.
package tcc_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int CNT_W     = 16;
  localparam int NUM_CHAN  = 7;

  // ----------------------------------------------------------------
  // Count modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MC_STOP  = 2'h0;
  localparam logic [1:0] MC_UP    = 2'h1;
  localparam logic [1:0] MC_CONT  = 2'h2;
  localparam logic [1:0] MC_UPDN  = 2'h3;

  // ----------------------------------------------------------------
  // Capture input select and edge select
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_FIRST  = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_GND    = 2'h2;
  localparam logic [1:0] SEL_VCC    = 2'h3;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;

  // ----------------------------------------------------------------
  // Latch load events and grouping
  // ----------------------------------------------------------------
  localparam logic [1:0] LD_IMM      = 2'h0;
  localparam logic [1:0] LD_ZERO     = 2'h1;
  localparam logic [1:0] LD_ZERO_PER = 2'h2;
  localparam logic [1:0] LD_OLD      = 2'h3;
  localparam logic [1:0] GRP_NONE    = 2'h0;
  localparam logic [1:0] GRP_PAIRS   = 2'h1;
  localparam logic [1:0] GRP_TRIPLES = 2'h2;
  localparam logic [1:0] GRP_ALL     = 2'h3;

  // ----------------------------------------------------------------
  // Output unit modes
  // ----------------------------------------------------------------
  localparam logic [2:0] OM_BIT = 3'h0;
  localparam logic [2:0] OM_SET = 3'h1;
  localparam logic [2:0] OM_TGR = 3'h2;
  localparam logic [2:0] OM_SR  = 3'h3;
  localparam logic [2:0] OM_TGL = 3'h4;
  localparam logic [2:0] OM_RST = 3'h5;
  localparam logic [2:0] OM_TGS = 3'h6;
  localparam logic [2:0] OM_RS  = 3'h7;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } tcc_dir_type;

  typedef struct packed {
    logic       measure_mode_bit;
    logic       capture_sync_bit;
    logic [1:0] input_select_field;
    logic [1:0] edge_select_field;
    logic [1:0] load_select_field;
    logic [2:0] out_mode;
    logic       out_bit;
  } tcc_cfg_type;

endpackage

// ### rtl/tcc_timer_capture_compare.sv
// Counter, capture/compare channels, grouped compare latches, output units.
// Assumes all inputs are synchronous to clk_i, the timer clock.
`timescale 1ns/1ps

module tcc_timer_capture_compare #(
  parameter int NCH = tcc_pkg::NUM_CHAN,
  parameter int CW  = tcc_pkg::CNT_W
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [1:0]                     count_mode_field_i,
  input  wire logic                           counter_clear_i,
  input  wire logic                           counter_write_i,
  input  wire logic [CW-1:0]                  counter_wdata_i,
  input  wire tcc_pkg::tcc_cfg_type [NCH-1:0] ch_cfg_i,
  input  wire logic [1:0]                     latch_group_field_i,
  input  wire logic [NCH-1:0]                 buf_write_i,
  input  wire logic [CW-1:0]                  buf_wdata_i,
  input  wire logic [NCH-1:0]                 buf_read_i,
  input  wire logic [NCH-1:0]                 flag_clear_i,
  input  wire logic [NCH-1:0]                 overflow_clear_i,
  input  wire logic [NCH-1:0]                 capture_input_first_i,
  input  wire logic [NCH-1:0]                 capture_input_second_i,
  input  wire logic                           float_select_i,
  input  wire logic                           output_float_pin_i,
  output logic [CW-1:0]                       counter_value_o,
  output logic                                count_down_o,
  output logic [NCH-1:0][CW-1:0]              channel_buffer_o,
  output logic [NCH-1:0]                      channel_flag_o,
  output logic [NCH-1:0]                      capture_overflow_o,
  output logic [NCH-1:0]                      input_level_o,
  output logic                                period_match_pulse_o,
  output logic [NCH-1:0]                      channel_match_pulse_o,
  output logic [NCH-1:0]                      timer_out_o,
  output logic [NCH-1:0]                      timer_out_oe_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int ctrl_of(input int ch, input logic [1:0] grp);
    int c;
    c = ch;
    case (grp)
      tcc_pkg::GRP_PAIRS:   c = (ch == 0) ? 0 : ((ch - 1) / 2) * 2 + 1;
      tcc_pkg::GRP_TRIPLES: c = (ch == 0) ? 0 : ((ch <= 3) ? 1 : 4);
      tcc_pkg::GRP_ALL:     c = 1;
      default:              c = ch;
    endcase
    return c;
  endfunction

  function automatic logic edge_hit(input logic [1:0] es,
                                    input logic rise,
                                    input logic fall);
    return ((es & tcc_pkg::EDGE_RISE) != 2'h0 && rise) ||
           ((es & tcc_pkg::EDGE_FALL) != 2'h0 && fall);
  endfunction

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [CW-1:0]        cnt_q;
  logic [CW-1:0]        cnt_d;
  tcc_pkg::tcc_dir_type dir_q;
  tcc_pkg::tcc_dir_type dir_d;
  logic                 counted_q;
  logic                 tick;
  logic [NCH-1:0][CW-1:0] latch_q;
  logic [CW-1:0]        period;

  assign period = latch_q[0];

  // A zero period in up or up/down mode halts the counter.
  assign tick = (count_mode_field_i != tcc_pkg::MC_STOP) &&
                !((count_mode_field_i != tcc_pkg::MC_CONT) &&
                  (period == '0));

  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    case (count_mode_field_i)
      tcc_pkg::MC_UP: begin
        cnt_d = (cnt_q >= period) ? '0 : cnt_q + 1'b1;
      end
      tcc_pkg::MC_CONT: begin
        cnt_d = cnt_q + 1'b1;
      end
      tcc_pkg::MC_UPDN: begin
        if (dir_q == tcc_pkg::DIR_UP) begin
          if (cnt_q >= period) begin
            dir_d = tcc_pkg::DIR_DOWN;
            cnt_d = cnt_q - 1'b1;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else if (cnt_q == '0) begin
          dir_d = tcc_pkg::DIR_UP;
          cnt_d = cnt_q + 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        cnt_d = cnt_q;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q     <= '0;
      dir_q     <= tcc_pkg::DIR_UP;
      counted_q <= 1'b0;
    end else if (counter_clear_i) begin
      cnt_q     <= '0;
      dir_q     <= tcc_pkg::DIR_UP;
      counted_q <= 1'b0;
    end else if (counter_write_i) begin
      cnt_q     <= counter_wdata_i;
      counted_q <= 1'b0;
    end else begin
      counted_q <= tick;
      if (tick) begin
        cnt_q <= cnt_d;
        dir_q <= dir_d;
      end
    end
  end

  assign counter_value_o = cnt_q;
  assign count_down_o    = (dir_q == tcc_pkg::DIR_DOWN);

  // Events only follow a real count step.
  logic           zero_ev;
  logic           per_ev;
  logic [NCH-1:0] hit_ev;

  assign zero_ev = counted_q && (cnt_q == '0);
  assign per_ev  = counted_q && (cnt_q == period);

  // ----------------------------------------------------------------
  // Capture path
  // ----------------------------------------------------------------
  logic [NCH-1:0] sel_lvl;
  logic [NCH-1:0] use_lvl;
  logic [NCH-1:0] sync_q;
  logic [NCH-1:0] prev_q;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] cmp_ev;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (ch_cfg_i[i].input_select_field)
        tcc_pkg::SEL_FIRST:  sel_lvl[i] = capture_input_first_i[i];
        tcc_pkg::SEL_SECOND: sel_lvl[i] = capture_input_second_i[i];
        tcc_pkg::SEL_GND:    sel_lvl[i] = 1'b0;
        default:             sel_lvl[i] = 1'b1;
      endcase
      use_lvl[i] = ch_cfg_i[i].capture_sync_bit ? sync_q[i]
                                                : sel_lvl[i];
      cap_ev[i]  = ch_cfg_i[i].measure_mode_bit &&
                   edge_hit(ch_cfg_i[i].edge_select_field,
                            use_lvl[i] && !prev_q[i],
                            !use_lvl[i] && prev_q[i]);
      hit_ev[i]  = counted_q && (cnt_q == latch_q[i]);
      cmp_ev[i]  = !ch_cfg_i[i].measure_mode_bit && hit_ev[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_q        <= '0;
      prev_q        <= '0;
      input_level_o <= '0;
    end else begin
      sync_q        <= sel_lvl;
      prev_q        <= use_lvl;
      input_level_o <= sel_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Buffers, flags and overflow
  // ----------------------------------------------------------------
  logic [NCH-1:0] unread_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_buffer_o   <= '0;
      channel_flag_o     <= '0;
      capture_overflow_o <= '0;
      unread_q           <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cap_ev[i]) begin
          channel_buffer_o[i] <= cnt_q;
        end else if (buf_write_i[i]) begin
          channel_buffer_o[i] <= buf_wdata_i;
        end
        // Hardware set wins over a software clear in the same cycle.
        if (cap_ev[i] || cmp_ev[i]) begin
          channel_flag_o[i] <= 1'b1;
        end else if (flag_clear_i[i]) begin
          channel_flag_o[i] <= 1'b0;
        end
        if (cap_ev[i] && unread_q[i]) begin
          capture_overflow_o[i] <= 1'b1;
        end else if (overflow_clear_i[i]) begin
          capture_overflow_o[i] <= 1'b0;
        end
        if (cap_ev[i]) begin
          unread_q[i] <= 1'b1;
        end else if (buf_read_i[i]) begin
          unread_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare latch loading and grouping
  // ----------------------------------------------------------------
  logic [NCH-1:0]      pend_q;
  logic [NCH-1:0]      imm_ld;
  logic [NCH-1:0]      ev_ld;
  logic [NCH-1:0][1:0] eff_ls;

  always_comb begin
    int  c;
    logic ev;
    logic ready;
    c     = 0;
    ev    = 1'b0;
    ready = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      c = ctrl_of(i, latch_group_field_i);
      if (c >= NCH) begin
        c = i;
      end
      eff_ls[i] = ch_cfg_i[c].load_select_field;
      // A zero controller load-select forces plain per-channel loads.
      if (eff_ls[i] == tcc_pkg::LD_IMM) begin
        c = i;
      end
      ready = 1'b1;
      for (int j = 0; j < NCH; j++) begin
        if (ctrl_of(j, latch_group_field_i) == c || j == i) begin
          ready = ready & pend_q[j];
        end
      end
      case (eff_ls[i])
        tcc_pkg::LD_ZERO:     ev = zero_ev;
        tcc_pkg::LD_ZERO_PER: ev = zero_ev ||
          (count_mode_field_i == tcc_pkg::MC_UPDN && per_ev);
        tcc_pkg::LD_OLD:      ev = hit_ev[i];
        default:              ev = 1'b0;
      endcase
      imm_ld[i] = buf_write_i[i] &&
                  (eff_ls[i] == tcc_pkg::LD_IMM);
      ev_ld[i]  = ev && ready;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= '0;
      pend_q  <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (imm_ld[i]) begin
          latch_q[i] <= buf_wdata_i;
        end else if (ev_ld[i]) begin
          latch_q[i] <= channel_buffer_o[i];
        end
        if (buf_write_i[i] && !imm_ld[i]) begin
          pend_q[i] <= 1'b1;
        end else if (ev_ld[i] || imm_ld[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output units
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_out_o           <= '0;
      timer_out_oe_o        <= '0;
      period_match_pulse_o  <= 1'b0;
      channel_match_pulse_o <= '0;
    end else begin
      period_match_pulse_o  <= per_ev;
      channel_match_pulse_o <= cmp_ev;
      for (int i = 0; i < NCH; i++) begin
        timer_out_oe_o[i] <= !(float_select_i &&
                               output_float_pin_i);
        case (ch_cfg_i[i].out_mode)
          tcc_pkg::OM_BIT: timer_out_o[i] <= ch_cfg_i[i].out_bit;
          tcc_pkg::OM_SET: if (cmp_ev[i]) timer_out_o[i] <= 1'b1;
          tcc_pkg::OM_TGR: begin
            if (per_ev) timer_out_o[i] <= 1'b0;
            else if (cmp_ev[i]) timer_out_o[i] <= !timer_out_o[i];
          end
          tcc_pkg::OM_SR: begin
            if (per_ev) timer_out_o[i] <= 1'b0;
            else if (cmp_ev[i]) timer_out_o[i] <= 1'b1;
          end
          tcc_pkg::OM_TGL: if (cmp_ev[i]) timer_out_o[i] <= !timer_out_o[i];
          tcc_pkg::OM_RST: if (cmp_ev[i]) timer_out_o[i] <= 1'b0;
          tcc_pkg::OM_TGS: begin
            if (per_ev) timer_out_o[i] <= 1'b1;
            else if (cmp_ev[i]) timer_out_o[i] <= !timer_out_o[i];
          end
          default: begin
            if (per_ev) timer_out_o[i] <= 1'b1;
            else if (cmp_ev[i]) timer_out_o[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic plain_step;
  assign plain_step = !counter_clear_i && !counter_write_i && tick;

  turn_down_a: assert property (
    plain_step && count_mode_field_i == tcc_pkg::MC_UPDN &&
    dir_q == tcc_pkg::DIR_UP && cnt_q > period
    |=> dir_q == tcc_pkg::DIR_DOWN && cnt_q == $past(cnt_q) - 1'b1)
    else $error("up count above period did not turn down");

  up_to_period_a: assert property (
    plain_step && count_mode_field_i == tcc_pkg::MC_UPDN &&
    dir_q == tcc_pkg::DIR_UP && cnt_q < period
    |=> dir_q == tcc_pkg::DIR_UP && cnt_q == $past(cnt_q) + 1'b1)
    else $error("up count below period did not keep rising");

  down_descent_a: assert property (
    plain_step && count_mode_field_i == tcc_pkg::MC_UPDN &&
    dir_q == tcc_pkg::DIR_DOWN && cnt_q != '0
    |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("down count left its descent");

  write_quiet_a: assert property (
    counter_write_i |=> !counted_q ##1 counted_q == $past(tick))
    else $error("counter write treated as a count");

  float_outs_a: assert property (
    float_select_i && output_float_pin_i |=> timer_out_oe_o == '0)
    else $error("outputs still driven while floated");

  for (genvar g = 0; g < NCH; g++) begin : g_chk
    capture_copy_a: assert property (
      cap_ev[g] |=> channel_buffer_o[g] == $past(cnt_q) &&
                    channel_flag_o[g])
      else $error("capture did not copy counter and set flag");

    overflow_set_a: assert property (
      cap_ev[g] && unread_q[g] |=> capture_overflow_o[g] [*2]
      or (capture_overflow_o[g] ##1 $past(overflow_clear_i[g])))
      else $error("second capture missed overflow");

    consumed_read_a: assert property (
      buf_read_i[g] && !cap_ev[g] |=> !unread_q[g])
      else $error("buffer read left the value unconsumed");

    imm_load_a: assert property (
      imm_ld[g] |=> latch_q[g] == $past(buf_wdata_i))
      else $error("immediate load missed");

    match_pulse_a: assert property (
      cmp_ev[g] |=> channel_match_pulse_o[g] && channel_flag_o[g])
      else $error("compare match without pulse or flag");
  end

endmodule // tcc_timer_capture_compare

// ### testbench/tcc_far_side.sv
// Far-side model: the capture input sources and the timer output pins.
// Assumes the bench calls set_in just after a rising edge of clk_i.
`timescale 1ns/1ps
module tcc_far_side #(
  parameter int NCH = 7
) (
  input  wire logic           clk_i,
  input  wire logic [NCH-1:0] out_i,
  input  wire logic [NCH-1:0] oe_i,
  output logic      [NCH-1:0] first_o,
  output logic      [NCH-1:0] second_o,
  output logic      [NCH-1:0] pin_o
);
  logic [NCH-1:0] last_q = '0;

  initial begin
    first_o  = '0;
    second_o = '0;
  end

  // A floated pin has no pull, so it shows the inverse of its last level.
  always @(posedge clk_i) begin
    last_q <= (oe_i & out_i) | (~oe_i & last_q);
  end

  assign pin_o = (oe_i & out_i) | (~oe_i & ~last_q);

  task automatic set_in(input int ch, input logic a, input logic b);
    first_o[ch]  = a;
    second_o[ch] = b;
  endtask
endmodule // tcc_far_side

// ### testbench/timer_capture_compare_tb.sv
// Self-checking bench for the timer capture/compare block.
// Assumes the package and the design are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module timer_capture_compare_tb;
  logic                       clk_i = 0;
  logic                       rst_n_i = 0;
  logic                       clr = 0;
  logic                       cwr = 0;
  logic                       fsel = 0;
  logic                       fpin = 0;
  logic [1:0]                 mode = 0;
  logic [1:0]                 grp = 0;
  logic [15:0]                cwd = 0;
  logic [15:0]                wd = 0;
  logic [6:0]                 bw = 0;
  logic [6:0]                 br = 0;
  logic [6:0]                 fclr = 0;
  logic [6:0]                 oclr = 0;
  tcc_pkg::tcc_cfg_type [6:0] cfg = '0;
  logic [6:0]                 first;
  logic [6:0]                 second;
  logic [6:0]                 pin;
  logic [15:0]                cnt;
  logic                       down;
  logic [6:0][15:0]           bufo;
  logic [6:0]                 flag;
  logic [6:0]                 ovf;
  logic [6:0]                 lvl;
  logic                       pmp;
  logic [6:0]                 cmp;
  logic [6:0]                 tout;
  logic [6:0]                 toe;
  logic [15:0]                ud [6] = '{16'h0001, 16'h0000, 16'h0001,
                                         16'h0002, 16'h0003, 16'h0002};
  int                         fail_count = 0;
  int                         compares = 0;

  always #12.5 clk_i = ~clk_i;

  tcc_timer_capture_compare #(.NCH(7), .CW(16)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .count_mode_field_i(mode),
    .counter_clear_i(clr), .counter_write_i(cwr), .counter_wdata_i(cwd),
    .ch_cfg_i(cfg), .latch_group_field_i(grp), .buf_write_i(bw),
    .buf_wdata_i(wd), .buf_read_i(br), .flag_clear_i(fclr),
    .overflow_clear_i(oclr), .capture_input_first_i(first),
    .capture_input_second_i(second), .float_select_i(fsel),
    .output_float_pin_i(fpin), .counter_value_o(cnt),
    .count_down_o(down), .channel_buffer_o(bufo), .channel_flag_o(flag),
    .capture_overflow_o(ovf), .input_level_o(lvl),
    .period_match_pulse_o(pmp), .channel_match_pulse_o(cmp),
    .timer_out_o(tout), .timer_out_oe_o(toe));

  tcc_far_side #(.NCH(7)) u_far (
    .clk_i(clk_i), .out_i(tout), .oe_i(toe), .first_o(first),
    .second_o(second), .pin_o(pin));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic pulse(ref logic [6:0] s, input int ch);
    s[ch] = 1'b1;
    tick();
    s[ch] = 1'b0;
  endtask

  task automatic wbuf(input int ch, input logic [15:0] v);
    wd = v;
    pulse(bw, ch);
  endtask

  task automatic setcnt(input logic [15:0] v);
    cwd = v;
    cwr = 1'b1;
    tick();
    cwr = 1'b0;
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    while (cnt !== v && n < 300) begin
      tick();
      n++;
    end
    `CHK("reach", v, cnt)
  endtask

  // The pulse shows one cycle after the count, so the latch is count-1.
  task automatic match_at(input int ch, input logic [15:0] e);
    int n;
    n = 0;
    while (cmp[ch] !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    `CHK("match", e, cnt - 16'h0001)
    tick();
  endtask

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    `CHK("oe_rst", 7'h00, toe)
    rst_n_i = 1'b1;
    tick(2);
    `CHK("oe", 7'h7F, toe)
    wbuf(0, 16'h0003);
    mode = tcc_pkg::MC_UPDN;
    wait_cnt(16'h0003);
    tick();
    `CHK("per_pulse", 1'b1, pmp)
    foreach (ud[i]) begin
      tick();
      `CHK("updown", ud[i], cnt)
    end
    wbuf(0, 16'h0001);
    tick();
    `CHK("descend", 16'h0000, cnt)
    tick();
    `CHK("new_per", 16'h0001, cnt)
    tick();
    `CHK("new_per", 16'h0000, cnt)
    wbuf(0, 16'h0006);
    wait_cnt(16'h0006);
    wait_cnt(16'h0000);
    wait_cnt(16'h0004);
    wbuf(0, 16'h0002);
    tick(2);
    `CHK("turn", 1'b1, down)
    mode = tcc_pkg::MC_STOP;
    setcnt(16'h1234);
    cfg[1].measure_mode_bit = 1'b1;
    cfg[1].edge_select_field = tcc_pkg::EDGE_RISE;
    u_far.set_in(1, 1'b1, 1'b0);
    tick(2);
    `CHK("cap", 16'h1234, bufo[1])
    `CHK("flag", 1'b1, flag[1])
    `CHK("level", 1'b1, lvl[1])
    `CHK("ovf", 1'b0, ovf[1])
    u_far.set_in(1, 1'b0, 1'b0);
    tick(2);
    `CHK("ovf_fall", 1'b0, ovf[1])
    u_far.set_in(1, 1'b1, 1'b0);
    tick(2);
    `CHK("ovf", 1'b1, ovf[1])
    pulse(oclr, 1);
    pulse(br, 1);
    pulse(fclr, 1);
    `CHK("ovf_clr", 1'b0, ovf[1])
    cfg[1].input_select_field = tcc_pkg::SEL_SECOND;
    cfg[1].edge_select_field = tcc_pkg::EDGE_FALL;
    u_far.set_in(1, 1'b1, 1'b1);
    setcnt(16'h00AB);
    u_far.set_in(1, 1'b1, 1'b0);
    tick(2);
    `CHK("cap_fall", 16'h00AB, bufo[1])
    `CHK("ovf_read", 1'b0, ovf[1])
    cfg[1].capture_sync_bit = 1'b1;
    cfg[1].input_select_field = tcc_pkg::SEL_GND;
    cfg[1].edge_select_field = 2'h3;
    pulse(br, 1);
    setcnt(16'h0055);
    pulse(fclr, 1);
    cfg[1].input_select_field = tcc_pkg::SEL_VCC;
    tick(3);
    `CHK("sw_cap", 16'h0055, bufo[1])
    `CHK("sync_flag", 1'b1, flag[1])
    pulse(br, 1);
    setcnt(16'h0066);
    cfg[1].input_select_field = tcc_pkg::SEL_GND;
    tick(3);
    `CHK("sw_cap", 16'h0066, bufo[1])
    `CHK("sw_ovf", 1'b0, ovf[1])
    cfg[2].out_mode = tcc_pkg::OM_SET;
    wbuf(2, 16'h0010);
    setcnt(16'h0010);
    tick(3);
    `CHK("no_event", 1'b0, cmp[2])
    setcnt(16'h0008);
    mode = tcc_pkg::MC_CONT;
    match_at(2, 16'h0010);
    `CHK("cmp_flag", 1'b1, flag[2])
    `CHK("out_set", 1'b1, tout[2])
    `CHK("pin", tout, pin)
    mode = tcc_pkg::MC_UP;
    cfg[1].measure_mode_bit = 1'b0;
    setcnt(16'h0000);
    wbuf(0, 16'h0028);
    wbuf(1, 16'h0005);
    wbuf(2, 16'h0006);
    grp = tcc_pkg::GRP_PAIRS;
    cfg[1].load_select_field = tcc_pkg::LD_ZERO;
    cfg[2].load_select_field = tcc_pkg::LD_OLD;
    wait_cnt(16'h0014);
    wbuf(1, 16'h000A);
    wait_cnt(16'h0000);
    match_at(1, 16'h0005);
    wbuf(2, 16'h000C);
    match_at(1, 16'h000A);
    match_at(2, 16'h000C);
    fsel = 1'b1;
    fpin = 1'b1;
    tick(2);
    `CHK("float", 7'h00, toe)
    fpin = 1'b0;
    tick(2);
    `CHK("drive", 7'h7F, toe)
    wrap_up();
  end
endmodule // timer_capture_compare_tb
